// >>> core/frt_pkg.sv
// package of constants and types shared by the fifo retransmit/flag block
package frt_pkg;

  // ----------------------------------------------------------------
  // geometry defaults
  // ----------------------------------------------------------------
  localparam int unsigned FRT_ADDR_W = 10;  // 1024 words in the array
  localparam int unsigned FRT_DATA_W = 36;

  // ----------------------------------------------------------------
  // retransmit setup timing
  // ----------------------------------------------------------------
  localparam int unsigned FRT_SETUP_W = 2;
  // setup cycles with reads blocked before the flag releases
  localparam logic [FRT_SETUP_W-1:0] FRT_SETUP_CYC = 2'h2;
  localparam logic [FRT_SETUP_W-1:0] FRT_SETUP_ONE = 2'h1;

  // ----------------------------------------------------------------
  // flag levels, all flags are active low
  // ----------------------------------------------------------------
  localparam logic FRT_FLAG_ON = 1'h0;
  localparam logic FRT_FLAG_OFF = 1'h1;

  // ----------------------------------------------------------------
  // control states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FRT_RUN = 2'h1,
    FRT_SETUP = 2'h2
  } frt_state_t;

endpackage

// >>> core/frt_level_cmp.sv
// threshold compare of a fifo fill level against a programmed offset
`timescale 1ns/1ps
`default_nettype none

module frt_level_cmp
  import frt_pkg::*;
#(
  parameter int unsigned W = FRT_ADDR_W + 1,
  parameter bit AT_LEAST = 1'b0
)
(
  // level and threshold
  input wire logic [W-1:0] level_in,
  input wire logic [W-1:0] thresh_in,
  // compare result
  output logic hit_out
);

  // at-least compare for the almost-full side, at-most for almost-empty
  assign hit_out = AT_LEAST ? (level_in >= thresh_in) : (level_in <= thresh_in);

endmodule
`default_nettype wire

// >>> core/frt_fifo_ctrl.sv
// single-clock fifo with retransmit control and status flag timing
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module frt_fifo_ctrl
  import frt_pkg::*;
#(
  parameter int unsigned ADDR_W = FRT_ADDR_W,
  parameter int unsigned DATA_W = FRT_DATA_W
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // resets and mode straps
  input wire logic master_reset_n_in,
  input wire logic partial_reset_n_in,
  input wire logic fall_through_mode_in,
  input wire logic retransmit_latency_select_in,
  input wire logic flag_timing_select_in,
  input wire logic [ADDR_W-1:0] aempty_offset_in,
  input wire logic [ADDR_W-1:0] afull_offset_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  // read port
  input wire logic rd_en_in,
  input wire logic retransmit_req_in,
  output logic [DATA_W-1:0] rd_data_out,
  // status flags
  output logic empty_flag_n_out,
  output logic full_flag_n_out,
  output logic output_ready_n_out,
  output logic input_ready_n_out,
  output logic prog_almost_empty_n_out,
  output logic prog_almost_full_n_out
);

  localparam int unsigned W = ADDR_W + 1;
  localparam logic [W-1:0] DEPTH_STD = {1'b1, {ADDR_W{1'b0}}};
  localparam logic [W-1:0] ONE_W = {{ADDR_W{1'b0}}, 1'b1};
  localparam logic [ADDR_W-1:0] FIRST_LOC = '0;
  localparam logic [ADDR_W-1:0] ONE_A = {{(ADDR_W-1){1'b0}}, 1'b1};

  typedef struct packed {
    frt_state_t st;
    logic [FRT_SETUP_W-1:0] setup_cnt;
    logic mode_fall;
    logic mode_retx_normal;
    logic mode_sync;
    logic [ADDR_W-1:0] aempty_off;
    logic [ADDR_W-1:0] afull_off;
    logic [ADDR_W-1:0] wptr;
    logic [ADDR_W-1:0] rptr;
    logic [W-1:0] count;
    logic out_valid;
    logic vis;
    logic empty_n;
    logic full_n;
    logic or_n;
    logic in_rdy_n;
    logic aempty_n;
    logic afull_n;
    logic [DATA_W-1:0] rd_data;
  } frt_regs_t;

  localparam frt_regs_t RST_S = '{st: FRT_RUN, empty_n: FRT_FLAG_ON, full_n: FRT_FLAG_OFF,
    or_n: FRT_FLAG_OFF, in_rdy_n: FRT_FLAG_OFF, aempty_n: FRT_FLAG_ON,
    afull_n: FRT_FLAG_OFF, default: '0};

  frt_regs_t s_ff;
  frt_regs_t nxt_s;
  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  logic rst_any;
  logic active;
  logic room;
  logic wr_ok;
  logic rd_ok;
  logic retx_hit;
  logic fetch;
  logic [W-1:0] lvl_cur;
  logic [W-1:0] lvl_no_wr;
  logic [W-1:0] lvl_no_rd;
  logic [W-1:0] lvl_all;
  logic [W-1:0] aempty_lvl;
  logic [W-1:0] afull_lvl;
  logic [W-1:0] afull_thr;
  logic [W-1:0] depth_tot;
  logic [W-1:0] cnt_wr;
  logic aempty_hit;
  logic afull_hit;

  // ----------------------------------------------------------------
  // port qualification
  // ----------------------------------------------------------------
  // setup blocks port reads in every cycle; its last cycle lets prefetch run and the flag release
  assign rst_any = !master_reset_n_in || !partial_reset_n_in;
  assign active = !(s_ff.st == FRT_SETUP && s_ff.setup_cnt != '0);
  assign room = s_ff.mode_fall ? !s_ff.in_rdy_n : s_ff.full_n;
  assign wr_ok = !rst_any && wr_en_in && room;
  assign rd_ok = !rst_any && rd_en_in && s_ff.st == FRT_RUN &&
    (s_ff.mode_fall ? !s_ff.or_n : s_ff.empty_n);
  assign retx_hit = !rst_any && retransmit_req_in && s_ff.st == FRT_RUN;
  // fall-through prefetch waits on the lagged visibility bit, giving two cycles
  assign fetch = !rst_any && !retx_hit && active &&
    (s_ff.mode_fall ? (s_ff.vis && (!s_ff.out_valid || rd_ok)) : rd_ok);

  // ----------------------------------------------------------------
  // fill levels for the programmable flags
  // ----------------------------------------------------------------
  // the output register adds the extra fall-through word
  assign depth_tot = DEPTH_STD + (s_ff.mode_fall ? ONE_W : '0);
  assign lvl_cur = s_ff.count + ((s_ff.mode_fall && s_ff.out_valid) ? ONE_W : '0);
  assign lvl_no_wr = lvl_cur - (rd_ok ? ONE_W : '0);
  assign lvl_no_rd = lvl_cur + (wr_ok ? ONE_W : '0);
  assign lvl_all = lvl_no_wr + (wr_ok ? ONE_W : '0);
  assign cnt_wr = s_ff.count + (wr_ok ? ONE_W : '0);
  // sync mode hides the releasing side for one cycle; async sees both at once
  assign aempty_lvl = s_ff.mode_sync ? lvl_no_wr : lvl_all;
  assign afull_lvl = s_ff.mode_sync ? lvl_no_rd : lvl_all;
  assign afull_thr = depth_tot - {1'b0, s_ff.afull_off};

  frt_level_cmp #(
    .W(W),
    .AT_LEAST(1'b0)
  ) u_aempty_cmp (
    .level_in(aempty_lvl),
    .thresh_in({1'b0, s_ff.aempty_off}),
    .hit_out(aempty_hit)
  );

  frt_level_cmp #(
    .W(W),
    .AT_LEAST(1'b1)
  ) u_afull_cmp (
    .level_in(afull_lvl),
    .thresh_in(afull_thr),
    .hit_out(afull_hit)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    if (rst_any)
    begin
      nxt_s = RST_S;
      nxt_s.mode_fall = s_ff.mode_fall;
      nxt_s.mode_retx_normal = s_ff.mode_retx_normal;
      nxt_s.mode_sync = s_ff.mode_sync;
      nxt_s.aempty_off = s_ff.aempty_off;
      nxt_s.afull_off = s_ff.afull_off;
      // partial reset keeps modes and offsets; only master reset loads them
      if (!master_reset_n_in)
      begin
        nxt_s.mode_fall = fall_through_mode_in;
        nxt_s.mode_retx_normal = retransmit_latency_select_in;
        nxt_s.mode_sync = flag_timing_select_in;
        nxt_s.aempty_off = aempty_offset_in;
        nxt_s.afull_off = afull_offset_in;
      end
      nxt_s.empty_n = nxt_s.mode_fall ? FRT_FLAG_OFF : FRT_FLAG_ON;
      nxt_s.in_rdy_n = nxt_s.mode_fall ? FRT_FLAG_ON : FRT_FLAG_OFF;
    end
    else if (retx_hit)
    begin
      // the writer keeps to at most depth-2 words, so the write pointer never wrapped
      nxt_s.wptr = s_ff.wptr + (wr_ok ? ONE_A : '0);
      nxt_s.rptr = s_ff.mode_retx_normal ? FIRST_LOC : ONE_A;
      nxt_s.count = {1'b0, nxt_s.wptr} - {1'b0, nxt_s.rptr};
      nxt_s.vis = ({1'b0, s_ff.wptr} - {1'b0, nxt_s.rptr}) != '0;
      if (s_ff.mode_retx_normal)
      begin
        nxt_s.st = FRT_SETUP;
        nxt_s.setup_cnt = FRT_SETUP_CYC - FRT_SETUP_ONE;
        nxt_s.out_valid = 1'b0;
        if (s_ff.mode_fall)
          nxt_s.or_n = FRT_FLAG_OFF;
        else
          nxt_s.empty_n = FRT_FLAG_ON;
      end
      else
      begin
        // zero latency: first word goes straight to the output register
        nxt_s.rd_data = mem_q[FIRST_LOC];
        if (s_ff.mode_fall)
        begin
          nxt_s.out_valid = 1'b1;
          nxt_s.or_n = FRT_FLAG_ON;
        end
        else
          nxt_s.empty_n = nxt_s.vis;
      end
    end
    else
    begin
      nxt_s.wptr = s_ff.wptr + (wr_ok ? ONE_A : '0);
      if (fetch)
      begin
        nxt_s.rptr = s_ff.rptr + ONE_A;
        nxt_s.rd_data = mem_q[s_ff.rptr];
      end
      nxt_s.count = cnt_wr - (fetch ? ONE_W : '0);
      // a write becomes visible to the read side one cycle late
      nxt_s.vis = (s_ff.count - (fetch ? ONE_W : '0)) != '0;
      if (s_ff.st == FRT_SETUP)
      begin
        if (s_ff.setup_cnt == '0)
          nxt_s.st = FRT_RUN;
        else
          nxt_s.setup_cnt = s_ff.setup_cnt - FRT_SETUP_ONE;
      end
      if (s_ff.mode_fall)
      begin
        nxt_s.out_valid = fetch || (s_ff.out_valid && !rd_ok);
        nxt_s.or_n = !nxt_s.out_valid;
        // a freed slot shows one cycle later since the read is not counted here
        nxt_s.in_rdy_n = !(cnt_wr < DEPTH_STD);
      end
      else
      begin
        nxt_s.empty_n = active ? nxt_s.vis : FRT_FLAG_ON;
        nxt_s.full_n = cnt_wr < DEPTH_STD;
      end
      nxt_s.aempty_n = !aempty_hit;
      nxt_s.afull_n = !afull_hit;
    end
  end

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      s_ff <= RST_S;
    else
      s_ff <= nxt_s;
  end

  // the array has no reset; contents are only trusted behind the pointers
  always_ff @(posedge clk_in)
  begin
    if (wr_ok)
      mem_q[s_ff.wptr] <= wr_data_in;
  end

  // outputs straight from the state register
  assign rd_data_out = s_ff.rd_data;
  assign empty_flag_n_out = s_ff.empty_n;
  assign full_flag_n_out = s_ff.full_n;
  assign output_ready_n_out = s_ff.or_n;
  assign input_ready_n_out = s_ff.in_rdy_n;
  assign prog_almost_empty_n_out = s_ff.aempty_n;
  assign prog_almost_full_n_out = s_ff.afull_n;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in || !master_reset_n_in || !partial_reset_n_in);

  logic std_retx_go;
  logic fall_retx_go;
  assign std_retx_go = retx_hit && !s_ff.mode_fall && s_ff.mode_retx_normal;
  assign fall_retx_go = retx_hit && s_ff.mode_fall && s_ff.mode_retx_normal;

  setup_ef_low_a: assert property (std_retx_go |=> !empty_flag_n_out [*2])
    else $error("empty flag not low during setup");
  setup_ef_done_a: assert property ((std_retx_go && s_ff.wptr != '0)
    |-> ##3 empty_flag_n_out)
    else $error("empty flag did not return after setup");
  setup_or_high_a: assert property (fall_retx_go |=> output_ready_n_out [*2])
    else $error("output-ready not high during setup");
  setup_or_done_a: assert property ((fall_retx_go && s_ff.wptr != '0)
    |-> ##3 !output_ready_n_out)
    else $error("output-ready did not drop after setup");
  zero_std_data_a: assert property ((retx_hit && !s_ff.mode_fall && !s_ff.mode_retx_normal)
    |=> rd_data_out == $past(mem_q[FIRST_LOC]))
    else $error("zero-latency first word missing");
  zero_fall_or_a: assert property ((retx_hit && s_ff.mode_fall && !s_ff.mode_retx_normal)
    |=> !output_ready_n_out && rd_data_out == $past(mem_q[FIRST_LOC]))
    else $error("zero-latency output-ready not updated");
  fall_first_word_a: assert property ((s_ff.mode_fall && wr_ok && !retx_hit &&
    s_ff.st == FRT_RUN && s_ff.count == '0 && !s_ff.out_valid && !retransmit_req_in)
    |=> output_ready_n_out ##1 output_ready_n_out ##1 !output_ready_n_out)
    else $error("output-ready latency wrong");
  fall_room_free_a: assert property ((s_ff.mode_fall && input_ready_n_out && rd_ok)
    |=> input_ready_n_out ##1 (!input_ready_n_out || $past(retx_hit)))
    else $error("input-ready late after read");
  depth_limit_a: assert property (lvl_cur <= depth_tot)
    else $error("fill level beyond depth");
  sync_aempty_rel_a: assert property ((s_ff.mode_sync && wr_ok && !rd_ok && !retx_hit &&
    lvl_cur == {1'b0, s_ff.aempty_off}) |=> !prog_almost_empty_n_out)
    else $error("sync almost-empty released early");
  async_aempty_rel_a: assert property ((!s_ff.mode_sync && wr_ok && !rd_ok && !retx_hit &&
    lvl_cur == {1'b0, s_ff.aempty_off}) |=> prog_almost_empty_n_out)
    else $error("async almost-empty not released");
  async_afull_set_a: assert property ((!s_ff.mode_sync && wr_ok && !rd_ok && !retx_hit &&
    lvl_no_rd == afull_thr) |=> !prog_almost_full_n_out)
    else $error("async almost-full not asserted");
  mode_latch_a: assert property ($rose(master_reset_n_in)
    |-> s_ff.mode_retx_normal == $past(retransmit_latency_select_in))
    else $error("latency select not latched");

  std_retx_c: cover property (std_retx_go ##3 empty_flag_n_out);
  fall_zero_retx_c: cover property (retx_hit && s_ff.mode_fall && !s_ff.mode_retx_normal);
  fall_full_c: cover property (s_ff.mode_fall && input_ready_n_out && rd_ok);

endmodule
`default_nettype wire

// >>> tb/frt_partner.sv
// writer and reader logic model on the far side of the fifo
`timescale 1ns/1ps
`default_nettype none

module frt_partner
  import frt_pkg::*;
#(
  parameter int unsigned ADDR_W = 3,
  parameter int unsigned DATA_W = FRT_DATA_W
)
(
  // clock
  input wire logic clk_in,
  // fifo status seen by the reader
  input wire logic fall_mode_in,
  input wire logic empty_flag_n_in,
  input wire logic output_ready_n_in,
  input wire logic [DATA_W-1:0] rd_data_in,
  // requests into the fifo
  output logic wr_en_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic rd_en_out,
  output logic retransmit_req_out
);
  int n_wr = 0;
  int n_rd = 0;

  // idle bus at time zero
  initial
  begin
    wr_en_out = 1'b0;
    wr_data_out = '0;
    rd_en_out = 1'b0;
    retransmit_req_out = 1'b0;
  end

  // counts restart with every master reset of the fifo
  task automatic clear();
    n_wr = 0;
    n_rd = 0;
  endtask

  // back to back writes, one word each
  task automatic push(input int n, input logic [DATA_W-1:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_in);
      wr_en_out <= 1'b1;
      wr_data_out <= base + DATA_W'(i);
    end
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    wr_data_out <= ~wr_data_out;  // stale data never looks like a fresh word
    n_wr += n;
    #1;
  endtask

  // one read; the reader holds off until a word is offered or 16 cycles pass
  task automatic pull(output logic [DATA_W-1:0] d);
    int w;
    w = 0;
    while (((fall_mode_in ? output_ready_n_in : ~empty_flag_n_in) !== 1'b0) && w < 16)
    begin
      @(posedge clk_in);
      #1;
      w++;
    end
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1;
    d = rd_data_in;
    n_rd++;
  endtask

  // retransmit only once enough words have passed, never near full
  task automatic retx();
    if (n_wr >= 2 && (fall_mode_in || n_rd >= 2) && n_wr <= 2 ** ADDR_W - 2)
    begin
      @(posedge clk_in);
      retransmit_req_out <= 1'b1;
      @(posedge clk_in);
      retransmit_req_out <= 1'b0;
    end
    #1;
  endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the fifo retransmit and flag block
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module tb;
  import frt_pkg::*;
  // ----------------------------------------------------------------
  // signals; a small array keeps fill scenarios short
  // ----------------------------------------------------------------
  localparam int unsigned AW = 3;
  localparam int unsigned DW = FRT_DATA_W;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic mrst_n = 1'b1;
  logic prst_n = 1'b1;
  logic fall_mode = 1'b0;
  logic lat_sel = 1'b1;
  logic timing_sel = 1'b1;
  logic [AW-1:0] n_off = '0;
  logic [AW-1:0] m_off = '0;
  logic wr_en, rd_en, retx_req;
  logic [DW-1:0] wr_data, rd_data, d;
  logic empty_n, full_n, or_n, in_rdy_n, aempty_n, afull_n;
  int n_fail = 0;
  int tests_run = 0;

  always #50 clk_in = ~clk_in;

  frt_fifo_ctrl #(.ADDR_W(AW), .DATA_W(DW)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .master_reset_n_in(mrst_n), .partial_reset_n_in(prst_n), .fall_through_mode_in(fall_mode),
    .retransmit_latency_select_in(lat_sel), .flag_timing_select_in(timing_sel),
    .aempty_offset_in(n_off), .afull_offset_in(m_off), .wr_en_in(wr_en),
    .wr_data_in(wr_data), .rd_en_in(rd_en), .retransmit_req_in(retx_req),
    .rd_data_out(rd_data), .empty_flag_n_out(empty_n),
    .full_flag_n_out(full_n), .output_ready_n_out(or_n), .input_ready_n_out(in_rdy_n),
    .prog_almost_empty_n_out(aempty_n), .prog_almost_full_n_out(afull_n));

  frt_partner #(.ADDR_W(AW), .DATA_W(DW)) u_part (.clk_in(clk_in), .fall_mode_in(fall_mode),
    .empty_flag_n_in(empty_n), .output_ready_n_in(or_n), .rd_data_in(rd_data),
    .wr_en_out(wr_en), .wr_data_out(wr_data), .rd_en_out(rd_en),
    .retransmit_req_out(retx_req));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  // master reset with the straps held steady across it
  task automatic mreset(input logic fw, input logic lat, input logic pf,
                        input logic [AW-1:0] n, input logic [AW-1:0] m);
    @(posedge clk_in);
    mrst_n <= 1'b0;
    fall_mode <= fw;
    lat_sel <= lat;
    timing_sel <= pf;
    n_off <= n;
    m_off <= m;
    @(posedge clk_in);
    mrst_n <= 1'b1;
    #1;
    u_part.clear();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog, over thirty times the expected run length
  initial
  begin
    #400000;
    n_fail++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    // standard, normal latency, synchronous almost flags
    mreset(1'b0, 1'b1, 1'b1, 3'h1, 3'h2);
    `CHK({empty_n, full_n, or_n, in_rdy_n}, 4'h7);
    u_part.push(1, 36'h0a0);
    u_part.push(1, 36'h0a1);
    `CHK(aempty_n, 1'b0);
    step();
    `CHK(aempty_n, 1'b1);
    u_part.push(1, 36'h0a2);
    u_part.pull(d);
    `CHK(d, 36'h0a0);
    u_part.pull(d);
    `CHK(d, 36'h0a1);
    u_part.retx();
    `CHK(empty_n, 1'b0);
    step();
    `CHK(empty_n, 1'b0);
    step();
    `CHK(empty_n, 1'b1);
    u_part.pull(d);
    `CHK(d, 36'h0a0);
    // standard fill, almost-full on write edges, release after read
    mreset(1'b0, 1'b1, 1'b1, 3'h1, 3'h2);
    u_part.push(6, 36'h0b0);
    `CHK(afull_n, 1'b0);
    u_part.push(3, 36'h0b6);
    `CHK(full_n, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      u_part.pull(d);
      `CHK(d, DW'(36'h0b0 + i));
    end
    `CHK(afull_n, 1'b0);
    step();
    `CHK(afull_n, 1'b1);
    // standard zero latency on an emptied fifo
    mreset(1'b0, 1'b0, 1'b1, 3'h1, 3'h2);
    u_part.push(2, 36'h0c0);
    u_part.pull(d);
    u_part.pull(d);
    u_part.retx();
    `CHK(rd_data, 36'h0c0);
    `CHK(empty_n, 1'b1);
    u_part.pull(d);
    `CHK(d, 36'h0c1);
    // fall-through, normal latency, asynchronous almost flags
    mreset(1'b1, 1'b1, 1'b0, 3'h1, 3'h1);
    `CHK({empty_n, or_n, in_rdy_n}, 3'h6);
    u_part.push(1, 36'h0d0);
    `CHK(or_n, 1'b1);
    step();
    `CHK(or_n, 1'b1);
    step();
    `CHK(or_n, 1'b0);
    `CHK(rd_data, 36'h0d0);
    u_part.push(1, 36'h0d1);
    `CHK(aempty_n, 1'b1);
    u_part.retx();
    `CHK(or_n, 1'b1);
    step();
    `CHK(or_n, 1'b1);
    step();
    `CHK(or_n, 1'b0);
    `CHK(rd_data, 36'h0d0);
    u_part.pull(d);
    `CHK(aempty_n, 1'b0);
    `CHK(rd_data, 36'h0d1);
    // fall-through zero latency on an emptied fifo
    mreset(1'b1, 1'b0, 1'b0, 3'h1, 3'h1);
    u_part.push(3, 36'h0e0);
    for (int i = 0; i < 3; i++)
    begin
      `CHK(rd_data, DW'(36'h0e0 + i));
      u_part.pull(d);
    end
    `CHK(or_n, 1'b1);
    u_part.retx();
    `CHK(or_n, 1'b0);
    `CHK(rd_data, 36'h0e0);
    // fall-through fill holds one word more than standard
    mreset(1'b1, 1'b0, 1'b0, 3'h1, 3'h1);
    u_part.push(8, 36'h0f0);
    `CHK(in_rdy_n, 1'b0);
    u_part.push(2, 36'h0f8);
    `CHK(in_rdy_n, 1'b1);
    `CHK(afull_n, 1'b0);
    u_part.pull(d);
    `CHK(in_rdy_n, 1'b1);
    step();
    `CHK(in_rdy_n, 1'b0);
    u_part.pull(d);
    `CHK(afull_n, 1'b1);
    `CHK(rd_data, 36'h0f2);
    // partial reset clears data but keeps the mode
    @(posedge clk_in);
    prst_n <= 1'b0;
    @(posedge clk_in);
    prst_n <= 1'b1;
    #1;
    `CHK({or_n, in_rdy_n}, 2'h2);
    stop_test();
  end
endmodule

`default_nettype wire
